//--- rtl/sysctl_regs.sv
// core system-control registers: flags, stack pointer, clock mode,
// interrupt enable and request
// assumes the cpu drives io_addr/io_wr/io_rd synchronously on core_clk
`timescale 1ns/100ps
`default_nettype none
`include "sysctl_defs.svh"
module sysctl_regs #(
  parameter logic [2:0] BROWNOUT_LEVEL = `BROWNOUT_DEF,
  parameter int SETTLE_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // reset cause: one when pin or watchdog caused the reset
  input wire logic warm_reset,
  // io register port
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  output logic [7:0] io_rdata,
  // alu flag update
  input wire logic alu_upd_z,
  input wire logic alu_z,
  input wire logic alu_upd_c,
  input wire logic alu_c,
  input wire logic alu_upd_arith,
  input wire logic alu_ac,
  input wire logic alu_ov,
  // stack pointer update from core
  input wire logic sp_upd,
  input wire logic [7:0] sp_new,
  // event sources
  input wire logic timer_event,
  input wire logic port_a_pin_zero,
  input wire logic port_b_pin_zero,
  input wire logic [1:0] pa0_edge_sel,
  input wire logic [1:0] pb0_edge_sel,
  // oscillator ready
  input wire logic osc_ready_fast,
  input wire logic osc_ready_crystal,
  input wire logic osc_ready_slow,
  // control outputs
  output logic fast_internal_osc_en,
  output logic slow_internal_osc_en,
  output logic watchdog_timer_en,
  output logic external_reset_pin_sel,
  output logic [1:0] clk_src,
  output logic [6:0] clk_div,
  output logic clk_gate_n,
  output logic irq_to_core,
  output logic [11:0] pc_start,
  output logic mem_keep,
  output logic [2:0] brownout_reset_level,
  output logic [7:0] stack_ptr
);
  initial begin
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin
      $error("SETTLE_CYCLES out of range");
    end
  end

  // ===========================================================
  // pin synchronisers
  logic [1:0] pa_sync_q, pa_sync_d, pb_sync_q, pb_sync_d;
  logic pa_last_q, pa_last_d, pb_last_q, pb_last_d;
  always_comb begin
    pa_sync_d = {pa_sync_q[0], port_a_pin_zero};
    pb_sync_d = {pb_sync_q[0], port_b_pin_zero};
    pa_last_d = pa_sync_q[1];
    pb_last_d = pb_sync_q[1];
  end
  always_ff @(posedge core_clk) begin
    // chain keeps tracking the pin through reset: no false edge after it
    pa_sync_q <= pa_sync_d;
    pb_sync_q <= pb_sync_d;
    pa_last_q <= pa_last_d;
    pb_last_q <= pb_last_d;
  end

  function automatic logic edge_hit(input logic now, input logic was,
                                    input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = now & ~was;
    fall = ~now & was;
    unique case (sel)
      `EDGE_BOTH: edge_hit = rise | fall;
      `EDGE_RISE: edge_hit = rise;
      `EDGE_FALL: edge_hit = fall;
      default: edge_hit = 1'b0; // reserved selection raises nothing
    endcase
  endfunction

  logic pa_evt, pb_evt;
  always_comb begin
    pa_evt = edge_hit(pa_sync_q[1], pa_last_q, pa0_edge_sel);
    pb_evt = edge_hit(pb_sync_q[1], pb_last_q, pb0_edge_sel);
  end

  // ===========================================================
  // registers
  logic [3:0] flags_q, flags_d;
  logic [7:0] sp_q, sp_d, clkmd_q, clkmd_d, inten_q, inten_d;
  logic [2:0] intrq_q, intrq_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [2:0] events;
  logic wr_flags, wr_sp, wr_clkmd, wr_inten, wr_intrq;

  always_comb begin
    wr_flags = io_wr && io_addr == `ADDR_FLAGS;
    wr_sp = io_wr && io_addr == `ADDR_SP;
    wr_clkmd = io_wr && io_addr == `ADDR_CLKMD;
    wr_inten = io_wr && io_addr == `ADDR_INTEN;
    wr_intrq = io_wr && io_addr == `ADDR_INTRQ;
    events = 3'h0;
    events[`IRQ_TMR] = timer_event;
    events[`IRQ_PB0] = pb_evt;
    events[`IRQ_PA0] = pa_evt;
    // software write first, alu update last so the live result wins
    flags_d = wr_flags ? io_wdata[3:0] : flags_q;
    if (alu_upd_arith) begin
      flags_d[`F_OV] = alu_ov;
      flags_d[`F_AC] = alu_ac;
    end
    if (alu_upd_c) flags_d[`F_C] = alu_c;
    if (alu_upd_z) flags_d[`F_Z] = alu_z;
    sp_d = sp_upd ? sp_new : (wr_sp ? io_wdata : sp_q);
    clkmd_d = wr_clkmd ? io_wdata : clkmd_q;
    inten_d = wr_inten ? io_wdata : inten_q;
    // set beats clear; set independent of enables
    intrq_d = (wr_intrq ? io_wdata[2:0] : intrq_q) | events;
    irq_d = |(intrq_q & inten_q[2:0]);
    rdata_d = rdata_q;
    if (io_rd) begin
      unique case (io_addr)
        `ADDR_FLAGS: rdata_d = {`FLAGS_RSVD, flags_q};
        `ADDR_SP: rdata_d = sp_q;
        `ADDR_CLKMD: rdata_d = clkmd_q;
        `ADDR_INTEN: rdata_d = inten_q;
        `ADDR_INTRQ: rdata_d = {5'h00, intrq_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= `RST_FLAGS;
      sp_q <= `RST_SP;
      clkmd_q <= `RST_CLKMD;
      inten_q <= `RST_INTEN;
      intrq_q <= 3'h0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      sp_q <= sp_d;
      clkmd_q <= clkmd_d;
      inten_q <= inten_d;
      intrq_q <= intrq_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  // ===========================================================
  // oscillator and watchdog controls
  logic fast_en_q, slow_en_q, wdt_en_q, rstpin_q, keep_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fast_en_q <= 1'b1;
      slow_en_q <= 1'b1;
      wdt_en_q <= 1'b1;
      rstpin_q <= 1'b0;
      keep_q <= 1'b0;
    end else begin
      fast_en_q <= clkmd_q[`BIT_FAST_EN];
      slow_en_q <= clkmd_q[`BIT_SLOW_EN];
      // slow oscillator off also stops the watchdog
      wdt_en_q <= clkmd_q[`BIT_WDT_EN] & clkmd_q[`BIT_SLOW_EN];
      rstpin_q <= clkmd_q[`BIT_RSTPIN];
      keep_q <= warm_reset;
    end
  end

  // ===========================================================
  // glitch-free clock switch
  sysctl_pkg::clk_src_e dec_src;
  logic [6:0] dec_div;
  logic dec_rsvd;
  clk_source_select u_sel (
    .sel(clkmd_q[7:5]),
    .type_one(clkmd_q[`BIT_TYPE]),
    .src(dec_src),
    .div(dec_div),
    .reserved(dec_rsvd)
  );

  sysctl_pkg::sw_state_e sw_q, sw_d;
  sysctl_pkg::clk_src_e src_q, src_d;
  logic [6:0] div_q, div_d;
  logic gate_n_q, gate_n_d;
  logic [7:0] cnt_q, cnt_d;
  logic target_ok;

  always_comb begin
    unique case (dec_src)
      sysctl_pkg::SRC_FAST: target_ok = clkmd_q[`BIT_FAST_EN] & osc_ready_fast;
      sysctl_pkg::SRC_CRYSTAL: target_ok = osc_ready_crystal;
      sysctl_pkg::SRC_SLOW: target_ok = clkmd_q[`BIT_SLOW_EN] & osc_ready_slow;
      default: target_ok = 1'b0;
    endcase
    sw_d = sw_q;
    src_d = src_q;
    div_d = div_q;
    gate_n_d = gate_n_q;
    cnt_d = cnt_q;
    // stop the clock, hold it low for a settle window, then resume
    unique case (sw_q)
      sysctl_pkg::SW_RUN: begin
        if (!dec_rsvd && target_ok && (dec_src != src_q || dec_div != div_q)) begin
          sw_d = sysctl_pkg::SW_DRAIN;
          gate_n_d = 1'b1;
          cnt_d = 8'(SETTLE_CYCLES);
        end
      end
      sysctl_pkg::SW_DRAIN: begin
        src_d = dec_src;
        div_d = dec_div;
        sw_d = sysctl_pkg::SW_SETTLE;
      end
      sysctl_pkg::SW_SETTLE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          gate_n_d = 1'b0;
          sw_d = sysctl_pkg::SW_RUN;
        end
      end
      default: sw_d = sysctl_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sw_q <= sysctl_pkg::SW_RUN;
      src_q <= sysctl_pkg::SRC_SLOW;
      div_q <= 7'h01;
      gate_n_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      sw_q <= sw_d;
      src_q <= src_d;
      div_q <= div_d;
      gate_n_q <= gate_n_d;
      cnt_q <= cnt_d;
    end
  end

  // ===========================================================
  // outputs
  logic [11:0] pc_q;
  logic [2:0] bo_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_q <= `PC_RESET;
      bo_q <= `BROWNOUT_DEF;
    end else begin
      pc_q <= `PC_RESET;
      bo_q <= BROWNOUT_LEVEL;
    end
  end

  always_comb begin
    io_rdata = rdata_q;
    irq_to_core = irq_q;
    fast_internal_osc_en = fast_en_q;
    slow_internal_osc_en = slow_en_q;
    watchdog_timer_en = wdt_en_q;
    external_reset_pin_sel = rstpin_q;
    clk_src = src_q;
    clk_div = div_q;
    clk_gate_n = gate_n_q;
    pc_start = pc_q;
    mem_keep = keep_q;
    brownout_reset_level = bo_q;
    stack_ptr = sp_q;
  end

  // ===========================================================
  // checks
  sequence s_switch_start;
    sw_q == sysctl_pkg::SW_RUN && sw_d == sysctl_pkg::SW_DRAIN;
  endsequence
  sequence s_clock_held;
    clk_gate_n [*2];
  endsequence

  property p_flags_ones;
    @(posedge core_clk) disable iff (reset)
      io_rd && io_addr == `ADDR_FLAGS |=> io_rdata[7:4] == `FLAGS_RSVD;
  endproperty
  a_flags_ones: assert property (p_flags_ones) else $error("flag high bits");

  property p_ov;
    @(posedge core_clk) disable iff (reset)
      alu_upd_arith |=> flags_q[`F_OV] == $past(alu_ov);
  endproperty
  a_ov: assert property (p_ov) else $error("overflow flag");

  property p_ac;
    @(posedge core_clk) disable iff (reset)
      alu_upd_arith |=> flags_q[`F_AC] == $past(alu_ac);
  endproperty
  a_ac: assert property (p_ac) else $error("nibble flag");

  property p_carry;
    @(posedge core_clk) disable iff (reset)
      alu_upd_c |=> flags_q[`F_C] == $past(alu_c);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag");

  property p_zero;
    @(posedge core_clk) disable iff (reset)
      alu_upd_z |=> flags_q[`F_Z] == $past(alu_z);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");

  property p_req_set;
    @(posedge core_clk) disable iff (reset)
      timer_event |=> intrq_q[`IRQ_TMR] ##1 irq_to_core == inten_q[`IRQ_TMR];
  endproperty
  a_req_set: assert property (p_req_set) else $error("timer request");

  property p_irq_gate;
    @(posedge core_clk) disable iff (reset)
      !$past(|(intrq_q & inten_q[2:0])) |-> !irq_to_core;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated irq");

  property p_wdt_slow;
    @(posedge core_clk) disable iff (reset)
      !clkmd_q[`BIT_SLOW_EN] |=> !watchdog_timer_en;
  endproperty
  a_wdt_slow: assert property (p_wdt_slow) else $error("watchdog on");

  property p_switch;
    @(posedge core_clk) disable iff (reset)
      s_switch_start |=> s_clock_held ##[1:256] !clk_gate_n;
  endproperty
  a_switch: assert property (p_switch) else $error("clock switch");

  property p_rstpin;
    @(posedge core_clk) disable iff (reset)
      wr_clkmd ##1 !wr_clkmd |=> external_reset_pin_sel == $past(io_wdata[0], 2);
  endproperty
  a_rstpin: assert property (p_rstpin) else $error("reset pin select");
endmodule
`default_nettype wire

//--- rtl/sysctl_defs.svh
// constants for the core system-control register group
// assumes an io-space register port driven by the cpu core on core_clk
// How it works
// - every reset returns registers to defaults
// - pin/watchdog reset keeps data memory
// - execution restarts at address zero
// - brownout level chosen from eight build options
// - status bits 7..4 always read ones
// - bit 3 flags signed overflow
// - bit 2 flags nibble carry or borrow
// - bit 1 flags carry, borrow, rotate
// - bit 0 flags zero result
// - stack pointer read/write, all eight bits stored as written
// - clock field plus type selects system clock
// - bit 4 enables fast oscillator, resets one
// - bit 2 slow oscillator, clear stops watchdog
// - bit 1 enables watchdog, resets one
// - bit 0 selects port pin or reset pin
// - enable bits gate timer, port b, port a
// - request bits set by hardware, software clears
// - pin events follow edge selection
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH
`define ADDR_FLAGS 8'h00
`define ADDR_SP 8'h02
`define ADDR_CLKMD 8'h03
`define ADDR_INTEN 8'h04
`define ADDR_INTRQ 8'h05
`define RST_CLKMD 8'hF6
`define RST_SP 8'h00
`define RST_INTEN 8'h00
`define RST_FLAGS 4'h0
`define FLAGS_RSVD 4'hF
`define PC_RESET 12'h000
`define BIT_FAST_EN 4
`define BIT_TYPE 3
`define BIT_SLOW_EN 2
`define BIT_WDT_EN 1
`define BIT_RSTPIN 0
`define F_OV 3
`define F_AC 2
`define F_C 1
`define F_Z 0
`define IRQ_TMR 2
`define IRQ_PB0 1
`define IRQ_PA0 0
`define INTEN_KEEP 7
`define BROWNOUT_DEF 3'h0
`define EDGE_BOTH 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`endif

//--- rtl/sysctl_pkg.sv
// types for the core system-control register group
// assumes sysctl_defs.svh sits beside it
package sysctl_pkg;
  typedef enum logic [1:0] {
    SRC_FAST = 2'h0,
    SRC_CRYSTAL = 2'h1,
    SRC_SLOW = 2'h2,
    SRC_NONE = 2'h3
  } clk_src_e;
  typedef enum logic [1:0] {
    SW_RUN = 2'h0,
    SW_DRAIN = 2'h1,
    SW_SETTLE = 2'h2
  } sw_state_e;
endpackage

//--- rtl/clk_source_select.sv
// decodes the clock field into source and divider, reserved codes flagged
// assumes purely combinational use inside the control group, registered out
`timescale 1ns/100ps
`default_nettype none
module clk_source_select (
  // clock mode fields
  input wire logic [2:0] sel,
  input wire logic type_one,
  // decoded choice
  output sysctl_pkg::clk_src_e src,
  output logic [6:0] div,
  output logic reserved
);
  always_comb begin
    src = sysctl_pkg::SRC_NONE;
    div = 7'h01;
    reserved = 1'b0;
    if (!type_one) begin
      unique case (sel)
        3'h0: begin src = sysctl_pkg::SRC_FAST; div = 7'h04; end
        3'h1: begin src = sysctl_pkg::SRC_FAST; div = 7'h02; end
        3'h3: begin src = sysctl_pkg::SRC_CRYSTAL; div = 7'h04; end
        3'h4: begin src = sysctl_pkg::SRC_CRYSTAL; div = 7'h02; end
        3'h5: begin src = sysctl_pkg::SRC_CRYSTAL; div = 7'h01; end
        3'h6: begin src = sysctl_pkg::SRC_SLOW; div = 7'h04; end
        3'h7: begin src = sysctl_pkg::SRC_SLOW; div = 7'h01; end
        default: reserved = 1'b1;
      endcase
    end else begin
      unique case (sel)
        3'h0: begin src = sysctl_pkg::SRC_FAST; div = 7'h10; end
        3'h1: begin src = sysctl_pkg::SRC_FAST; div = 7'h08; end
        3'h3: begin src = sysctl_pkg::SRC_FAST; div = 7'h20; end
        3'h4: begin src = sysctl_pkg::SRC_FAST; div = 7'h40; end
        3'h5: begin src = sysctl_pkg::SRC_CRYSTAL; div = 7'h08; end
        default: reserved = 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- tb/core_system_control_regs_bench.sv
// testbench for the core system-control register group
// assumes sysctl_regs and sysctl_defs.svh from rtl/, one 250 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "sysctl_defs.svh"
module core_system_control_regs_bench;
  // ==========================================================
  // stimulus and observed signals
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  typedef struct {logic [7:0] d; logic [1:0] src; logic [6:0] div;} clk_row_s;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic warm_reset = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, sp_new = 8'h00;
  logic io_wr = 1'b0, io_rd = 1'b0, sp_upd = 1'b0;
  logic upd_z = 1'b0, alu_z = 1'b0, upd_c = 1'b0, alu_c = 1'b0;
  logic upd_ar = 1'b0, alu_ac = 1'b0, alu_ov = 1'b0;
  logic timer_event = 1'b0, pa0 = 1'b0, pb0 = 1'b0;
  logic [1:0] edge_sel = 2'h0;
  logic rdy_fast = 1'b1, rdy_xtal = 1'b0, rdy_slow = 1'b1;
  logic [7:0] io_rdata, stack_ptr;
  logic fast_en, slow_en, wdt_en, rst_sel, clk_gate_n, irq, mem_keep;
  logic [1:0] clk_src;
  logic [1:0] src_prev = 2'h2;
  logic [6:0] clk_div;
  logic [11:0] pc_start;
  logic [2:0] bor_level;
  int bad_count = 0;
  int cmp_count = 0;
  // short settle count keeps the clock-switch tests quick
  sysctl_regs #(.BROWNOUT_LEVEL(3'h5), .SETTLE_CYCLES(1)) dut (
    .core_clk(core_clk), .reset(reset), .warm_reset(warm_reset),
    .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd),
    .io_rdata(io_rdata), .alu_upd_z(upd_z), .alu_z(alu_z),
    .alu_upd_c(upd_c), .alu_c(alu_c), .alu_upd_arith(upd_ar),
    .alu_ac(alu_ac), .alu_ov(alu_ov), .sp_upd(sp_upd), .sp_new(sp_new),
    .timer_event(timer_event), .port_a_pin_zero(pa0),
    .port_b_pin_zero(pb0), .pa0_edge_sel(edge_sel),
    .pb0_edge_sel(edge_sel), .osc_ready_fast(rdy_fast),
    .osc_ready_crystal(rdy_xtal), .osc_ready_slow(rdy_slow),
    .fast_internal_osc_en(fast_en), .slow_internal_osc_en(slow_en),
    .watchdog_timer_en(wdt_en), .external_reset_pin_sel(rst_sel),
    .clk_src(clk_src), .clk_div(clk_div), .clk_gate_n(clk_gate_n),
    .irq_to_core(irq), .pc_start(pc_start), .mem_keep(mem_keep),
    .brownout_reset_level(bor_level), .stack_ptr(stack_ptr));
  always #2 core_clk = ~core_clk;
  // ==========================================================
  // shared tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] seen,
                     input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [7:0] e);
    @(posedge core_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    ticks(1);
    chk(nm, io_rdata, e);
  endtask
  task automatic do_reset(input logic warm, input int n);
    @(posedge core_clk);
    reset <= 1'b1;
    warm_reset <= warm;
    ticks(n);
    reset <= 1'b0;
    ticks(1);
    chk("mem_keep", mem_keep, warm);
    chk("clkmd", {fast_en, slow_en, wdt_en, rst_sel}, 4'hE);
    chk("clk_src", {clk_src, clk_div}, {2'h2, 7'h01});
    chk("gate irq", {clk_gate_n, irq}, 2'h0);
    chk("pc_start", pc_start, `PC_RESET);
    chk("brownout", bor_level, 3'h5);
    rd("clkmd", `ADDR_CLKMD, `RST_CLKMD);
    rd("sp", `ADDR_SP, `RST_SP);
    rd("inten", `ADDR_INTEN, `RST_INTEN);
    rd("intrq", `ADDR_INTRQ, 8'h00);
    rd("flags", `ADDR_FLAGS, 8'hF0);
  endtask
  // source may only move while the gate holds the clock
  always @(posedge core_clk) begin
    if (!reset && clk_src !== src_prev) begin
      chk("gate at switch", clk_gate_n, 1'b1);
    end
    src_prev <= clk_src;
  end
  // ==========================================================
  // main sequence
  row_s rows [10] = '{
    '{`ADDR_SP, 8'hAA, 8'hAA}, '{`ADDR_SP, 8'h54, 8'h54},
    '{`ADDR_INTEN, 8'h87, 8'h87}, '{`ADDR_INTEN, 8'h80, 8'h80},
    '{`ADDR_FLAGS, 8'h0A, 8'hFA}, '{`ADDR_FLAGS, 8'h05, 8'hF5},
    '{`ADDR_FLAGS, 8'h00, 8'hF0}, '{8'h01, 8'h55, 8'h00},
    '{8'h06, 8'h33, 8'h00}, '{`ADDR_CLKMD, 8'hF6, 8'hF6}};
  // crystal never ready, reserved code and crystal rows must be ignored
  clk_row_s crows [7] = '{
    '{8'h36, 2'h0, 7'h02}, '{8'h76, 2'h0, 7'h02}, '{8'h56, 2'h0, 7'h02},
    '{8'h1E, 2'h0, 7'h10}, '{8'h3E, 2'h0, 7'h08}, '{8'hD6, 2'h2, 7'h04},
    '{8'hF6, 2'h2, 7'h01}};
  initial begin
    do_reset(1'b0, 16);
    wr(`ADDR_INTEN, 8'h80);
    wr(`ADDR_INTRQ, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd("reg row", rows[i].a, rows[i].e);
    end
    foreach (crows[i]) begin
      wr(`ADDR_CLKMD, crows[i].d);
      ticks(12);
      chk("clock row", {clk_src, clk_div}, {crows[i].src, crows[i].div});
    end
    wr(`ADDR_CLKMD, 8'hE3);
    ticks(3);
    chk("osc off", {fast_en, slow_en, wdt_en, rst_sel}, 4'h1);
    wr(`ADDR_CLKMD, 8'hF4);
    ticks(3);
    chk("wdt off", {fast_en, slow_en, wdt_en, rst_sel}, 4'hC);
    @(posedge core_clk);
    {upd_z, upd_c, upd_ar, alu_z, alu_c, alu_ac, alu_ov} <= 7'h7F;
    @(posedge core_clk);
    {upd_z, upd_c, upd_ar, alu_z, alu_c, alu_ac, alu_ov} <= 7'h70;
    @(posedge core_clk);
    {upd_z, upd_c, upd_ar} <= 3'h0;
    rd("flags zero", `ADDR_FLAGS, 8'hF0);
    @(posedge core_clk);
    {upd_z, upd_c, upd_ar, alu_z, alu_c, alu_ac, alu_ov} <= 7'h7F;
    @(posedge core_clk);
    {upd_z, upd_c, upd_ar} <= 3'h0;
    rd("flags set", `ADDR_FLAGS, 8'hFF);
    for (int s = 0; s < 4; s++) begin
      edge_sel <= 2'(s);
      wr(`ADDR_INTRQ, 8'h00);
      pa0 <= 1'b1;
      pb0 <= 1'b1;
      ticks(6);
      rd("rise", `ADDR_INTRQ, {6'h0, {2{s == 0 || s == 1}}});
      wr(`ADDR_INTRQ, 8'h00);
      pa0 <= 1'b0;
      pb0 <= 1'b0;
      ticks(6);
      rd("fall", `ADDR_INTRQ, {6'h0, {2{s == 0 || s == 2}}});
    end
    @(posedge core_clk);
    timer_event <= 1'b1;
    @(posedge core_clk);
    timer_event <= 1'b0;
    ticks(3);
    chk("irq masked", irq, 1'b0);
    rd("timer req", `ADDR_INTRQ, 8'h04);
    wr(`ADDR_INTEN, 8'h84);
    ticks(3);
    chk("irq on", irq, 1'b1);
    wr(`ADDR_INTRQ, 8'h03);
    ticks(3);
    chk("irq cleared", irq, 1'b0);
    @(posedge core_clk);
    sp_upd <= 1'b1;
    sp_new <= 8'h3E;
    @(posedge core_clk);
    sp_upd <= 1'b0;
    ticks(1);
    chk("stack_ptr", stack_ptr, 8'h3E);
    rd("sp core", `ADDR_SP, 8'h3E);
    rd("keep bit", `ADDR_INTEN, 8'h84);
    do_reset(1'b1, 2);
    do_reset(1'b0, 1);
    test_done();
  end
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
